// ===== hw/temp_link_port.sv
// Link-clock side of the register port: byte framing and handshakes
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defines.svh"
module temp_link_port
  import temp_sensor_pkg::*;
(
  input  wire logic        link_clock,
  input  wire logic        rst_n,
  input  wire logic        link_frame,
  input  wire logic        link_read,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte_data,
  input  wire logic [15:0] read_word,
  input  wire logic        read_ack_tog,
  output logic             write_tog,
  output logic [7:0]       write_byte,
  output logic [1:0]       write_index,
  output logic             read_tog,
  output logic [7:0]       link_read_data,
  output logic             link_data_ready
);
  link_state_t st;
  link_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; reset is rst_n brought over two flops first
  always_comb begin
    next_st = st;
    next_st.rst_s1 = rst_n;
    next_st.rst_s2 = st.rst_s1;
    next_st.ack_s1 = read_ack_tog;
    next_st.ack_s2 = st.ack_s1;
    next_st.frame_d = link_frame;
    if (!st.rst_s2) begin
      next_st.idx = `BYTE_PTR;
      next_st.wr_tog = 1'b0;
      next_st.wr_byte = 8'h00;
      next_st.wr_idx = `BYTE_PTR;
      next_st.rd_tog = 1'b0;
      next_st.ack_seen = 1'b0;
      next_st.word = 16'h0000;
      next_st.rd_lsb = 1'b0;
      next_st.out = 8'h00;
      next_st.ready = 1'b0;
    end else begin
      // Frame start: new byte count, a read asks the core for a word
      if (link_frame && !st.frame_d) begin
        next_st.idx = `BYTE_PTR;
        if (link_read) begin
          next_st.rd_tog = ~st.rd_tog;
          next_st.ready = 1'b0;
          next_st.rd_lsb = 1'b0;
        end
      end
      // Core answered: word is stable, present the high byte first
      if (st.ack_s2 != st.ack_seen) begin
        next_st.ack_seen = st.ack_s2;
        next_st.word = read_word;
        next_st.out = read_word[15:8];
        next_st.ready = 1'b1;
      end
      if (link_byte_valid && link_frame) begin
        if (link_read) begin
          // Host may stop after the high byte; low byte follows otherwise
          next_st.out = st.rd_lsb ? 8'h00 : st.word[7:0];
          next_st.rd_lsb = 1'b1;
        end else begin
          // Byte held steady for the core until the next toggle
          next_st.wr_byte = link_byte_data;
          next_st.wr_idx = st.idx;
          next_st.wr_tog = ~st.wr_tog;
          if (st.idx != `BYTE_DONE) begin
            next_st.idx = st.idx + 2'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge link_clock) begin
    st <= next_st;
  end

  assign write_tog = st.wr_tog;
  assign write_byte = st.wr_byte;
  assign write_index = st.wr_idx;
  assign read_tog = st.rd_tog;
  assign link_read_data = st.out;
  assign link_data_ready = st.ready;
endmodule
`default_nettype wire

// ===== hw/temp_sensor_defines.svh
// Offsets, field positions, reset values and timing figures of the sensor core
`ifndef TEMP_SENSOR_DEFINES_SVH
`define TEMP_SENSOR_DEFINES_SVH
// Register select codes in the low pointer bits
`define SEL_TEMP 2'h0
`define SEL_CONFIG 2'h1
`define SEL_LOW 2'h2
`define SEL_HIGH 2'h3
// Byte position inside a write frame
`define BYTE_PTR 2'h0
`define BYTE_MSB 2'h1
`define BYTE_LSB 2'h2
`define BYTE_DONE 2'h3
// Reset values
`define PTR_RESET 8'h00
`define CFG_RESET_HI 8'h60
`define CFG_RESET_LO 8'hA0
`define LOW_RESET 16'h4B00
`define HIGH_RESET 16'h5000
// Field positions in the 16-bit configuration word
`define CFG_OS 15
`define CFG_RES 13
`define CFG_FAULT 11
`define CFG_POL 10
`define CFG_TM 9
`define CFG_SD 8
`define CFG_RATE 6
`define CFG_AL 5
`define CFG_EM 4
`define RES_FIXED 2'h3
// Fault queue depths
`define FAULT_N0 3'h1
`define FAULT_N1 3'h2
`define FAULT_N2 3'h4
`define FAULT_N3 3'h6
// Normal format saturation bounds
`define NORM_MAX 13'h07FF
`define NORM_MIN 13'h1800
// Timing
`define CLOCK_MHZ 50
`define CONV_TIME_US 26000
`define RATE0_MS 4000
`define RATE1_MS 1000
`define RATE2_MS 250
`define RATE3_MS 125
`endif

// ===== hw/temp_sensor_mode_regs.sv
// Mode control, conversion sequencing and register bank of the sensor
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defines.svh"
module temp_sensor_mode_regs
  import temp_sensor_pkg::*;
#(
  parameter logic [31:0] CONV_CYCLES    = `CONV_TIME_US * `CLOCK_MHZ,
  parameter logic [31:0] PERIOD0_CYCLES = `RATE0_MS * 1000 * `CLOCK_MHZ,
  parameter logic [31:0] PERIOD1_CYCLES = `RATE1_MS * 1000 * `CLOCK_MHZ,
  parameter logic [31:0] PERIOD2_CYCLES = `RATE2_MS * 1000 * `CLOCK_MHZ,
  parameter logic [31:0] PERIOD3_CYCLES = `RATE3_MS * 1000 * `CLOCK_MHZ
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        link_clock,
  input  wire logic        link_frame,
  input  wire logic        link_read,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte_data,
  input  wire logic [12:0] adc_value,
  output logic [7:0]       link_read_data,
  output logic             link_data_ready,
  output logic             converting,
  output logic             alert_level
);
  localparam logic [15:0] CFG_RESET = {`CFG_RESET_HI, `CFG_RESET_LO};

  core_state_t st;
  core_state_t next_st;

  logic              write_tog;
  logic [7:0]        write_byte;
  logic [1:0]        write_index;
  logic              read_tog;
  logic              wr_event;
  logic              rd_event;
  logic              conv_done;
  logic              os_trig;
  logic [31:0]       period;
  logic [2:0]        fault_need;
  logic signed [12:0] tval;
  logic signed [12:0] low_val;
  logic signed [12:0] high_val;
  logic              over_high;
  logic              under_low;
  logic [2:0]        hi_next;
  logic [2:0]        lo_next;
  logic              comp_next;
  logic [15:0]       cfg_word;
  logic              cur_act;

  ////////////////////////////////////////////////////////////////////////////
  // Link-clock side; only toggles and steady words cross to this domain
  temp_link_port u_link (
    .link_clock      (link_clock),
    .rst_n           (rst_n),
    .link_frame      (link_frame),
    .link_read       (link_read),
    .link_byte_valid (link_byte_valid),
    .link_byte_data  (link_byte_data),
    .read_word       (st.snap),
    .read_ack_tog    (st.rd_ack),
    .write_tog       (write_tog),
    .write_byte      (write_byte),
    .write_index     (write_index),
    .read_tog        (read_tog),
    .link_read_data  (link_read_data),
    .link_data_ready (link_data_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Limit decode by current format, signed
  function automatic logic signed [12:0] decode(input logic [15:0] r,
                                                input logic em);
    decode = em ? $signed(r[15:3]) : $signed({r[15], r[15:4]});
  endfunction

  // Events from the link; data words are steady once a toggle lands
  assign wr_event = st.wr_s2 != st.wr_seen;
  assign rd_event = st.rd_s2 != st.rd_seen;
  assign conv_done = (st.state == ST_CONVERT) && (st.cnt == CONV_CYCLES - 32'h1);
  assign os_trig = wr_event && (write_index == `BYTE_MSB)
                   && (st.ptr[1:0] == `SEL_CONFIG)
                   && write_byte[`CFG_OS - 8] && (st.state == ST_SHUT);

  // Rate period and fault depth lookups
  always_comb begin
    unique case (st.rate)
      2'h0: period = PERIOD0_CYCLES;
      2'h1: period = PERIOD1_CYCLES;
      2'h2: period = PERIOD2_CYCLES;
      2'h3: period = PERIOD3_CYCLES;
    endcase
    unique case (st.fault_sel)
      2'h0: fault_need = `FAULT_N0;
      2'h1: fault_need = `FAULT_N1;
      2'h2: fault_need = `FAULT_N2;
      2'h3: fault_need = `FAULT_N3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fresh sample in the active format and fault bookkeeping
  always_comb begin
    if (st.em) begin
      tval = $signed(adc_value);
    end else if ($signed(adc_value) > $signed(`NORM_MAX)) begin
      tval = $signed(`NORM_MAX);
    end else if ($signed(adc_value) < $signed(`NORM_MIN)) begin
      tval = $signed(`NORM_MIN);
    end else begin
      tval = $signed(adc_value);
    end
    low_val = decode(st.low, st.em);
    high_val = decode(st.high, st.em);
    over_high = tval >= high_val;
    under_low = tval < low_val;
    hi_next = over_high ? ((st.hi_cnt == 3'h7) ? 3'h7 : st.hi_cnt + 3'h1) : 3'h0;
    lo_next = under_low ? ((st.lo_cnt == 3'h7) ? 3'h7 : st.lo_cnt + 3'h1) : 3'h0;
    // Comparator needs the same fault depth to set and to release
    comp_next = st.comp_act;
    if (!st.comp_act && hi_next >= fault_need) begin
      comp_next = 1'b1;
    end else if (st.comp_act && lo_next >= fault_need) begin
      comp_next = 1'b0;
    end
  end

  // Configuration read image; resolution is fixed
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[`CFG_OS] = st.os_flag;
    cfg_word[`CFG_RES +: 2] = `RES_FIXED;
    cfg_word[`CFG_FAULT +: 2] = st.fault_sel;
    cfg_word[`CFG_POL] = st.alert_polarity;
    cfg_word[`CFG_TM] = st.tm;
    cfg_word[`CFG_SD] = st.sd;
    cfg_word[`CFG_RATE +: 2] = st.rate;
    cfg_word[`CFG_AL] = ~(st.comp_act ^ st.alert_polarity);
    cfg_word[`CFG_EM] = st.em;
  end

  assign cur_act = st.tm ? st.int_act : st.comp_act;

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole core
  always_comb begin
    next_st = st;
    // Two-flop crossings of the link toggles
    next_st.wr_s1 = write_tog;
    next_st.wr_s2 = st.wr_s1;
    next_st.rd_s1 = read_tog;
    next_st.rd_s2 = st.rd_s1;
    if (!rst_n) begin
      next_st.ptr = `PTR_RESET;
      next_st.os_flag = CFG_RESET[`CFG_OS];
      next_st.fault_sel = CFG_RESET[`CFG_FAULT +: 2];
      next_st.alert_polarity = CFG_RESET[`CFG_POL];
      next_st.tm = CFG_RESET[`CFG_TM];
      next_st.sd = CFG_RESET[`CFG_SD];
      next_st.rate = CFG_RESET[`CFG_RATE +: 2];
      next_st.em = CFG_RESET[`CFG_EM];
      next_st.temp = 16'h0000;
      next_st.low = `LOW_RESET;
      next_st.high = `HIGH_RESET;
      next_st.snap = 16'h0000;
      // Power-up starts a conversion at once
      next_st.state = ST_CONVERT;
      next_st.cnt = 32'h0;
      next_st.one_run = 1'b0;
      next_st.hi_cnt = 3'h0;
      next_st.lo_cnt = 3'h0;
      next_st.comp_act = 1'b0;
      next_st.int_act = 1'b0;
      next_st.wr_s1 = 1'b0;
      next_st.wr_s2 = 1'b0;
      next_st.wr_seen = 1'b0;
      next_st.rd_s1 = 1'b0;
      next_st.rd_s2 = 1'b0;
      next_st.rd_seen = 1'b0;
      next_st.rd_ack = 1'b0;
    end else begin
      // Register writes, one byte per event
      if (wr_event) begin
        next_st.wr_seen = st.wr_s2;
        unique case (write_index)
          `BYTE_PTR: next_st.ptr = write_byte;
          `BYTE_MSB: begin
            unique case (st.ptr[1:0])
              `SEL_CONFIG: begin
                next_st.fault_sel = write_byte[`CFG_FAULT - 8 +: 2];
                next_st.alert_polarity = write_byte[`CFG_POL - 8];
                next_st.tm = write_byte[`CFG_TM - 8];
                next_st.sd = write_byte[`CFG_SD - 8];
              end
              `SEL_LOW: next_st.low[15:8] = write_byte;
              `SEL_HIGH: next_st.high[15:8] = write_byte;
              `SEL_TEMP: next_st.temp = st.temp;
            endcase
          end
          `BYTE_LSB: begin
            unique case (st.ptr[1:0])
              `SEL_CONFIG: begin
                next_st.rate = write_byte[`CFG_RATE +: 2];
                next_st.em = write_byte[`CFG_EM];
              end
              `SEL_LOW: next_st.low[7:0] = write_byte;
              `SEL_HIGH: next_st.high[7:0] = write_byte;
              `SEL_TEMP: next_st.temp = st.temp;
            endcase
          end
          `BYTE_DONE: next_st.ptr = st.ptr;
        endcase
      end
      // Read request: freeze the selected word and answer the link
      if (rd_event) begin
        next_st.rd_seen = st.rd_s2;
        next_st.rd_ack = ~st.rd_ack;
        unique case (st.ptr[1:0])
          `SEL_TEMP: next_st.snap = st.temp;
          `SEL_CONFIG: next_st.snap = cfg_word;
          `SEL_LOW: next_st.snap = st.low;
          `SEL_HIGH: next_st.snap = st.high;
        endcase
        if (st.ptr[1:0] == `SEL_TEMP) begin
          next_st.int_act = 1'b0;
        end
      end
      // Conversion sequencer
      unique case (st.state)
        ST_CONVERT: begin
          next_st.cnt = st.cnt + 32'h1;
          if (conv_done) begin
            // New result always overwrites the old one
            next_st.temp = st.em ? {tval, 2'b00, 1'b1}
                                 : {tval[11:0], 4'h0};
            next_st.hi_cnt = hi_next;
            next_st.lo_cnt = lo_next;
            next_st.comp_act = comp_next;
            if (st.one_run || st.sd) begin
              next_st.state = ST_SHUT;
              next_st.one_run = 1'b0;
              next_st.os_flag = st.one_run ? 1'b1 : st.os_flag;
            end else begin
              next_st.state = ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Idle until the rate period from conversion start runs out
          next_st.cnt = st.cnt + 32'h1;
          if (st.sd) begin
            next_st.state = ST_SHUT;
          end else if (st.cnt >= period - 32'h1) begin
            next_st.state = ST_CONVERT;
            next_st.cnt = 32'h0;
          end
        end
        ST_SHUT: begin
          // Only the register port stays live here
          next_st.cnt = 32'h0;
          if (os_trig) begin
            next_st.state = ST_CONVERT;
            next_st.one_run = 1'b1;
            next_st.os_flag = 1'b0;
          end else if (!st.sd) begin
            next_st.state = ST_CONVERT;
          end
        end
      endcase
      // Interrupt alert: clear on entering shutdown, set wins last
      if (next_st.state == ST_SHUT && st.state != ST_SHUT) begin
        next_st.int_act = 1'b0;
      end
      if (conv_done && st.tm && comp_next != st.comp_act) begin
        next_st.int_act = 1'b1;
      end
    end
    next_st.converting = next_st.state == ST_CONVERT;
    next_st.alert_level = ~((next_st.tm ? next_st.int_act : next_st.comp_act)
                            ^ next_st.alert_polarity);
  end

  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign converting = st.converting;
  assign alert_level = st.alert_level;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  fmt_normal_a: assert property (
    conv_done && !st.em |=> st.temp[3:0] == 4'h0)
    else $error("normal format low nibble not zero");
  fmt_ext_a: assert property (
    conv_done && st.em |=> st.temp[2:0] == 3'b001)
    else $error("extended format low bits wrong");
  stop_after_a: assert property (
    conv_done && st.sd |=> st.state == ST_SHUT ##1 st.state == ST_SHUT
      || $past(os_trig))
    else $error("power-down did not stop converting");
  cont_run_a: assert property (
    conv_done && !st.sd && !st.one_run |=> st.state == ST_WAIT)
    else $error("continuous mode stopped");
  one_shot_a: assert property (
    os_trig |=> st.state == ST_CONVERT && st.one_run && !st.os_flag)
    else $error("single conversion not started");
  os_read_a: assert property (
    st.one_run && conv_done |=> st.os_flag && st.state == ST_SHUT)
    else $error("trigger bit not back to one");
  conv_len_a: assert property (
    $rose(st.state == ST_CONVERT) |-> st.cnt == 32'h0)
    else $error("conversion started with stale count");
  alert_pol_a: assert property (
    st.alert_level == ~(cur_act ^ st.alert_polarity))
    else $error("alert pin level wrong for polarity");
  int_clear_a: assert property (
    rd_event && st.ptr[1:0] == `SEL_TEMP && !conv_done |=> !st.int_act)
    else $error("interrupt alert not cleared by result read");
  fault_q_a: assert property (
    $rose(st.comp_act) |-> st.hi_cnt >= fault_need)
    else $error("alert raised before fault count");
  byte_wise_a: assert property (
    wr_event && write_index == `BYTE_MSB && st.ptr[1:0] == `SEL_LOW
      |=> st.low[7:0] == $past(st.low[7:0]))
    else $error("high byte write touched low byte");
  res_ro_a: assert property (
    rd_event && st.ptr[1:0] == `SEL_CONFIG |=> st.snap[14:13] == 2'b11)
    else $error("resolution bits not fixed");
endmodule
`default_nettype wire

// ===== hw/temp_sensor_pkg.sv
// Types shared by the sensor core and its link port
package temp_sensor_pkg;
  typedef enum logic [2:0] {
    ST_CONVERT = 3'b001,
    ST_WAIT    = 3'b010,
    ST_SHUT    = 3'b100
  } conv_state_t;

  typedef struct packed {
    logic [7:0]  ptr;
    logic        os_flag;
    logic [1:0]  fault_sel;
    logic        alert_polarity;
    logic        tm;
    logic        sd;
    logic [1:0]  rate;
    logic        em;
    logic [15:0] temp;
    logic [15:0] low;
    logic [15:0] high;
    logic [15:0] snap;
    conv_state_t state;
    logic [31:0] cnt;
    logic        one_run;
    logic [2:0]  hi_cnt;
    logic [2:0]  lo_cnt;
    logic        comp_act;
    logic        int_act;
    logic        wr_s1;
    logic        wr_s2;
    logic        wr_seen;
    logic        rd_s1;
    logic        rd_s2;
    logic        rd_seen;
    logic        rd_ack;
    logic        alert_level;
    logic        converting;
  } core_state_t;

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        frame_d;
    logic [1:0]  idx;
    logic        wr_tog;
    logic [7:0]  wr_byte;
    logic [1:0]  wr_idx;
    logic        rd_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic [15:0] word;
    logic        rd_lsb;
    logic [7:0]  out;
    logic        ready;
  } link_state_t;
endpackage

// ===== testbench/temp_link_host.sv
// Byte-level two-wire host model with its own gated link clock
`timescale 1ns/1ps
`default_nettype none
module temp_link_host (
  input  wire logic       rst_n,
  input  wire logic [7:0] link_read_data,
  input  wire logic       link_data_ready,
  output logic            link_clock,
  output logic            link_frame,
  output logic            link_read,
  output logic            link_byte_valid,
  output logic [7:0]      link_byte_data
);
  logic busy;
  // Clock runs in frames and in reset only, off phase with the core
  initial begin
    {link_clock, link_frame, link_read, link_byte_valid, busy} = '0;
    link_byte_data = 8'hA5;
    #1.7;
    forever #3 link_clock = (busy || !rst_n) ? ~link_clock : 1'b0;
  end
  // Wide gap keeps bytes well over six core periods apart
  task automatic send(input logic [7:0] b);
    repeat (25) @(negedge link_clock);
    link_byte_data = b;
    link_byte_valid = 1'b1;
    @(negedge link_clock);
    link_byte_valid = 1'b0;
    link_byte_data = ~b;
  endtask
  task automatic open_frame(input logic rd);
    busy = 1'b1;
    repeat (2) @(negedge link_clock);
    link_read = rd;
    link_frame = 1'b1;
  endtask
  task automatic close_frame();
    repeat (4) @(negedge link_clock);
    link_frame = 1'b0;
    link_read = 1'b0;
    repeat (3) @(negedge link_clock);
    busy = 1'b0;
  endtask
  // Pointer byte then n data bytes
  task automatic write_reg(input logic [1:0] sel, input logic [15:0] v, input int n);
    open_frame(1'b0);
    send({6'h00, sel});
    if (n > 0) send(v[15:8]);
    if (n > 1) send(v[7:0]);
    close_frame();
  endtask
  // High byte first; a one-byte read leaves the low byte zero
  task automatic read_reg(input int n, output logic [15:0] w, output logic ok);
    int i;
    w = 16'h0000;
    open_frame(1'b1);
    // Ready still shows the last frame until the frame edge is seen
    @(negedge link_clock);
    for (i = 0; i < 100 && link_data_ready !== 1'b1; i++) @(negedge link_clock);
    ok = (link_data_ready === 1'b1);
    w[15:8] = link_read_data;
    send(8'h00);
    if (n > 1) begin
      repeat (2) @(negedge link_clock);
      w[7:0] = link_read_data;
      send(8'h00);
    end
    close_frame();
  endtask
endmodule
`default_nettype wire

// ===== testbench/temp_sensor_mode_regs_bench.sv
// Register, format, alert and shutdown sequences for the sensor core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module temp_sensor_mode_regs_bench;
  import temp_sensor_pkg::*;
  logic        clock;
  logic        rst_n;
  logic [12:0] adc_value;
  logic [15:0] w;
  logic        ok;
  logic        lck, lfr, lrd, lbv, ldr, converting, alert_level;
  logic [7:0]  lbd, lrdata;
  int          err_count, n_checks, f, r;
  int          fq[4] = '{1, 2, 4, 6};
  temp_sensor_mode_regs #(.CONV_CYCLES(20), .PERIOD0_CYCLES(80), .PERIOD1_CYCLES(60),
    .PERIOD2_CYCLES(40), .PERIOD3_CYCLES(30)) DUT (.clock(clock), .rst_n(rst_n),
    .link_clock(lck), .link_frame(lfr), .link_read(lrd), .link_byte_valid(lbv),
    .link_byte_data(lbd), .adc_value(adc_value), .link_read_data(lrdata),
    .link_data_ready(ldr), .converting(converting), .alert_level(alert_level));
  temp_link_host host (.rst_n(rst_n), .link_read_data(lrdata), .link_data_ready(ldr),
    .link_clock(lck), .link_frame(lfr), .link_read(lrd), .link_byte_valid(lbv),
    .link_byte_data(lbd));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Writable fields in place, resolution fixed, rate 4 Hz, status zero
  function automatic logic [15:0] cfg(input logic [1:0] fc, input logic alert_polarity, tm, sd, em);
    return {1'b0, 2'h3, fc, alert_polarity, tm, sd, 2'h2, 1'b0, em, 4'h0};
  endfunction
  // Waits out n conversion ends; a stuck converter ends the run
  task automatic wait_conv(input int n);
    int k, t;
    for (k = 0; k < n; k++) begin
      for (t = 0; t < 500 && converting !== 1'b1; t++) @(negedge clock);
      // A converter that never starts counts as stuck as well
      if (t < 500) begin
        for (t = 0; t < 500 && converting !== 1'b0; t++) @(negedge clock);
      end
      if (t == 500) begin
        err_count++;
        complete_run();
      end
    end
    repeat (4) @(negedge clock);
  endtask
  task automatic count_conv(output int rises);
    logic prev;
    rises = 0;
    prev = converting;
    repeat (300) begin
      @(negedge clock);
      if (converting === 1'b1 && prev !== 1'b1) rises++;
      prev = converting;
    end
  endtask
  task automatic chk_reg(input logic [1:0] sel, input int n, input logic [15:0] ex);
    host.write_reg(sel, 16'h0000, 0);
    host.read_reg(n, w, ok);
    if (ok !== 1'b1) begin
      err_count++;
      complete_run();
    end
    `CHK("register", ex, w)
  endtask
  initial begin
    rst_n = 1'b0;
    adc_value = 13'h0190;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    wait_conv(1);
    host.read_reg(2, w, ok);
    `CHK("result", 16'h1900, w)
    chk_reg(2'h1, 2, 16'h60A0);
    chk_reg(2'h2, 2, 16'h4B00);
    chk_reg(2'h3, 2, 16'h5000);
    // Hot reading saturates in normal format, full width in extended
    adc_value = 13'h0A00;
    wait_conv(2);
    chk_reg(2'h0, 2, 16'h7FF0);
    host.write_reg(2'h1, cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 2);
    wait_conv(2);
    chk_reg(2'h0, 2, 16'h5001);
    chk_reg(2'h0, 1, 16'h5000);
    adc_value = 13'h0170;
    host.write_reg(2'h1, 16'h0000, 2);
    wait_conv(2);
    chk_reg(2'h1, 2, 16'h6020);
    host.write_reg(2'h0, 16'hFFFF, 2);
    chk_reg(2'h0, 2, 16'h1700);
    host.write_reg(2'h3, 16'h55AA, 1);
    chk_reg(2'h3, 2, 16'h5500);
    host.write_reg(2'h3, 16'h1A00, 2);
    host.write_reg(2'h2, 16'h1800, 2);
    chk_reg(2'h2, 2, 16'h1800);
    $display("test registers done");
    // Alert waits for exactly the queued number of hot results
    for (f = 0; f < 4; f++) begin
      host.write_reg(2'h1, cfg(f[1:0], 1'b0, 1'b0, 1'b0, 1'b0), 2);
      adc_value = 13'h0170;
      wait_conv(fq[f] + 1);
      adc_value = 13'h01A0;
      wait_conv(fq[f] - 1);
      `CHK("alert", 1'b1, alert_level)
      wait_conv(1);
      `CHK("alert", 1'b0, alert_level)
    end
    adc_value = 13'h0190;
    wait_conv(2);
    `CHK("alert", 1'b0, alert_level)
    chk_reg(2'h1, 2, cfg(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
    host.write_reg(2'h1, cfg(2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 2);
    repeat (10) @(negedge clock);
    `CHK("alert", 1'b1, alert_level)
    chk_reg(2'h1, 2, cfg(2'h3, 1'b1, 1'b0, 1'b0, 1'b0) | 16'h0020);
    // Interrupt: cleared by a result read, fires on the next change
    host.write_reg(2'h1, cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b0), 2);
    chk_reg(2'h0, 2, 16'h1900);
    wait_conv(2);
    `CHK("alert", 1'b1, alert_level)
    adc_value = 13'h0170;
    wait_conv(2);
    `CHK("alert", 1'b0, alert_level)
    chk_reg(2'h0, 2, 16'h1700);
    `CHK("alert", 1'b1, alert_level)
    adc_value = 13'h01A0;
    wait_conv(1);
    `CHK("alert", 1'b0, alert_level)
    $display("test alerts done");
    host.write_reg(2'h1, cfg(2'h0, 1'b0, 1'b1, 1'b1, 1'b0), 2);
    repeat (40) @(negedge clock);
    `CHK("alert", 1'b1, alert_level)
    count_conv(r);
    `CHK("runs", 0, r)
    chk_reg(2'h3, 2, 16'h1A00);
    adc_value = 13'h0150;
    host.write_reg(2'h1, cfg(2'h0, 1'b0, 1'b1, 1'b1, 1'b0) | 16'h8000, 2);
    wait_conv(1);
    count_conv(r);
    `CHK("runs", 0, r)
    chk_reg(2'h0, 2, 16'h1500);
    chk_reg(2'h1, 2, cfg(2'h0, 1'b0, 1'b1, 1'b1, 1'b0) | 16'h8020);
    $display("test shutdown done");
    complete_run();
  end
endmodule
`default_nettype wire
